// [src/stl_top.sv]
// torque limit select: ahb-lite registers, limit selection and output clamp
`timescale 1ns/100ps
`default_nettype none
module stl_top
    import stl_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic        hreadyout,
    output var  logic        hresp,
    output var  logic [31:0] hrdata,
    input  wire logic        fwd_ext_limit_in,
    input  wire logic        rev_ext_limit_in,
    input  wire logic signed [15:0] torque_req,
    output var  logic signed [15:0] torque_out,
    output var  logic        torque_limited_out
);
    import stl_pkg::*;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [STL_LIM_W-1:0] fwd_int_reg;
    logic [STL_LIM_W-1:0] rev_int_reg;
    logic [STL_LIM_W-1:0] fwd_ext_reg;
    logic [STL_LIM_W-1:0] rev_ext_reg;
    logic [STL_LIM_W-1:0] mot_max_reg;
    logic [STL_CFG_W-1:0] cfg_reg;
    logic                 wr_pend_reg;
    logic [7:0]           wr_addr_reg;
    logic                 limited_reg;
    logic [STL_LIM_W-1:0] lim_wdata;
    logic                 addr_hit;
    logic                 take_req;
    logic [31:0]          rd_next;
    logic [STL_LIM_W-1:0] eff_lim [2];

    // ------------------------------------------------------------
    // ahb slave
    // ------------------------------------------------------------
    // always zero wait state; hsize is not checked, only whole words are used
    // hreadyout low in reset keeps the master off until the registers settle
    assign take_req = hsel && hready && (htrans == STL_HTRANS_NONSEQ);
    assign addr_hit = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);
    // saturate oversize writes to the four limit registers to the top of the range; motor max and config take hwdata as is
    assign lim_wdata = (hwdata > {16'h0000, STL_LIM_MAX}) ? STL_LIM_MAX
                                                         : hwdata[15:0];

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            hreadyout <= 1'b0;
            hresp     <= STL_HRESP_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= STL_HRESP_OKAY;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            // hwdata only stands in the data phase, so the write lands a cycle late
            wr_pend_reg <= take_req && hwrite && addr_hit;
            wr_addr_reg <= haddr[7:0];
        end
    end

    always_comb begin
        rd_next = 32'h00000000;
        if (addr_hit) begin
            case (haddr[7:0])
                STL_OFS_FWD_INT: rd_next = {16'h0000, fwd_int_reg};
                STL_OFS_REV_INT: rd_next = {16'h0000, rev_int_reg};
                STL_OFS_FWD_EXT: rd_next = {16'h0000, fwd_ext_reg};
                STL_OFS_REV_EXT: rd_next = {16'h0000, rev_ext_reg};
                STL_OFS_CONFIG:  rd_next = {28'h0000000, cfg_reg};
                STL_OFS_MOT_MAX: rd_next = {16'h0000, mot_max_reg};
                STL_OFS_STATUS:  rd_next = {29'h00000000, rev_ext_limit_in,
                                            fwd_ext_limit_in, limited_reg};
                STL_OFS_EFF_LIM: rd_next = {eff_lim[1], eff_lim[0]};
                default:         rd_next = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            hrdata <= 32'h00000000;
        end else if (take_req && !hwrite) begin
            hrdata <= rd_next;
        end
    end

    // ------------------------------------------------------------
    // limit parameters, used the cycle after the data phase
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            fwd_int_reg <= STL_INT_RST;
            rev_int_reg <= STL_INT_RST;
            fwd_ext_reg <= STL_EXT_RST;
            rev_ext_reg <= STL_EXT_RST;
        end else if (wr_pend_reg) begin
            case (wr_addr_reg)
                STL_OFS_FWD_INT: fwd_int_reg <= lim_wdata;
                STL_OFS_REV_INT: rev_int_reg <= lim_wdata;
                STL_OFS_FWD_EXT: fwd_ext_reg <= lim_wdata;
                STL_OFS_REV_EXT: rev_ext_reg <= lim_wdata;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_reg     <= STL_CFG_RST;
            mot_max_reg <= STL_MOT_MAX_RST;
        end else if (wr_pend_reg) begin
            if (wr_addr_reg == STL_OFS_CONFIG) begin
                cfg_reg <= hwdata[STL_CFG_W-1:0];
            end
            if (wr_addr_reg == STL_OFS_MOT_MAX) begin
                mot_max_reg <= hwdata[15:0];
            end
        end
    end

    // ------------------------------------------------------------
    // effective limits, index 0 forward, 1 reverse
    // ------------------------------------------------------------
    logic [STL_LIM_W-1:0] int_lim [2];
    logic [STL_LIM_W-1:0] ext_lim [2];
    logic                 ext_on  [2];

    assign int_lim[0] = fwd_int_reg;
    assign int_lim[1] = rev_int_reg;
    assign ext_lim[0] = fwd_ext_reg;
    assign ext_lim[1] = rev_ext_reg;
    // unallocated inputs are masked off here
    assign ext_on[0]  = fwd_ext_limit_in && cfg_reg[STL_CFG_FWD_ALLOC];
    assign ext_on[1]  = rev_ext_limit_in && cfg_reg[STL_CFG_REV_ALLOC];

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_dir
            stl_dir_limit u_lim (
                .int_lim   (int_lim[gi]),
                .ext_lim   (ext_lim[gi]),
                .ext_on    (ext_on[gi]),
                .motor_max (mot_max_reg),
                .eff_lim   (eff_lim[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // torque clamp
    // ------------------------------------------------------------
    logic        [STL_LIM_W-1:0] pos_lim;
    logic        [STL_LIM_W-1:0] neg_lim;
    logic signed [16:0]          req_x;
    logic signed [16:0]          pos_x;
    logic signed [16:0]          neg_x;
    logic                        over_pos;
    logic                        over_neg;

    // dir select 0: ccw positive torque is forward; 1 swaps the pair
    assign pos_lim  = cfg_reg[STL_CFG_DIR_SEL] ? eff_lim[1] : eff_lim[0];
    assign neg_lim  = cfg_reg[STL_CFG_DIR_SEL] ? eff_lim[0] : eff_lim[1];
    // one extra bit so -800 and a full-scale request compare without overflow
    assign req_x    = {torque_req[15], torque_req};
    assign pos_x    = {1'b0, pos_lim};
    assign neg_x    = -{1'b0, neg_lim};
    assign over_pos = req_x > pos_x;
    assign over_neg = req_x < neg_x;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            torque_out <= 16'sh0000;
        end else if (over_pos) begin
            torque_out <= pos_x[15:0];
        end else if (over_neg) begin
            torque_out <= neg_x[15:0];
        end else begin
            torque_out <= torque_req;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            limited_reg        <= 1'b0;
            torque_limited_out <= 1'b0;
        end else begin
            // raw flag stays readable in status even when the pin is not allocated
            limited_reg        <= over_pos || over_neg;
            torque_limited_out <= (over_pos || over_neg)
                                  && cfg_reg[STL_CFG_OUT_ALLOC];
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    // every check sleeps while reset is held
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    logic first_reg;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            first_reg <= 1'b1;
        end else begin
            first_reg <= 1'b0;
        end
    end

    AST_CLAMP_POS: assert property (over_pos |=> torque_out == $past(pos_x[15:0])
        && torque_out >= 16'sh0000)
        else $error("positive torque not clamped to forward limit");
    AST_RANGE: assert property (fwd_int_reg <= STL_LIM_MAX && rev_int_reg <= STL_LIM_MAX
        && fwd_ext_reg <= STL_LIM_MAX && rev_ext_reg <= STL_LIM_MAX)
        else $error("limit parameter above range");
    AST_RESET_VAL: assert property (first_reg |-> fwd_int_reg == 16'h0320
        && rev_int_reg == 16'h0320 && fwd_ext_reg == 16'h0064 && rev_ext_reg == 16'h0064)
        else $error("limit parameters wrong after reset");
    AST_MOT_MAX: assert property (eff_lim[0] <= mot_max_reg && eff_lim[1] <= mot_max_reg)
        else $error("effective limit above motor maximum");
    AST_FWD_SEL: assert property (ext_on[0] |-> eff_lim[0] <= fwd_ext_reg
        && eff_lim[0] <= fwd_int_reg)
        else $error("forward limit not the smaller one");
    AST_REV_OFF: assert property (!rev_ext_limit_in && rev_int_reg <= mot_max_reg
        |-> eff_lim[1] == rev_int_reg)
        else $error("reverse external limit applied while off");
    AST_WRITE_NOW: assert property (take_req && hwrite && haddr == 32'h00000000
        ##1 1'b1 |=> fwd_int_reg == (($past(hwdata) > 32'h00000320) ? 16'h0320
                                     : $past(hwdata[15:0])))
        else $error("forward limit write did not take effect");
    AST_STATUS: assert property (1'b1
        |=> limited_reg == $past(over_pos || over_neg))
        else $error("limited status does not follow clamp");
    AST_UNALLOC: assert property (!cfg_reg[STL_CFG_FWD_ALLOC] && fwd_int_reg <= mot_max_reg
        |-> eff_lim[0] == fwd_int_reg)
        else $error("forward external limit used while unallocated");
    AST_OUT_ALLOC: assert property (!cfg_reg[STL_CFG_OUT_ALLOC] |=> !torque_limited_out)
        else $error("status output driven while unallocated");
    AST_DIR_SWAP: assert property (cfg_reg[STL_CFG_DIR_SEL] && over_neg
        |=> torque_out == -$signed({1'b0, $past(eff_lim[0][14:0])}))
        else $error("direction select not honoured");
    AST_PASS: assert property (!over_pos && !over_neg |=> torque_out == $past(torque_req)
        && !limited_reg)
        else $error("unclamped torque altered");
    AST_CLAMP_NEG: assert property (over_neg |=> torque_out == $past(neg_x[15:0])
        && torque_out <= 16'sh0000)
        else $error("negative torque not clamped to reverse limit");
    AST_FWD_OFF: assert property (!fwd_ext_limit_in && fwd_int_reg <= mot_max_reg
        |-> eff_lim[0] == fwd_int_reg)
        else $error("forward external limit applied while off");
    AST_REV_SEL: assert property (ext_on[1] |-> eff_lim[1] <= rev_ext_reg
        && eff_lim[1] <= rev_int_reg)
        else $error("reverse limit not the smaller one");
    AST_REV_UNALLOC: assert property (!cfg_reg[STL_CFG_REV_ALLOC]
        && rev_int_reg <= mot_max_reg |-> eff_lim[1] == rev_int_reg)
        else $error("reverse external limit used while unallocated");
    AST_LIM_OUT: assert property (cfg_reg[STL_CFG_OUT_ALLOC]
        |=> torque_limited_out == limited_reg)
        else $error("status output does not follow limited flag");

    // ------------------------------------------------------------
    // cover points
    // ------------------------------------------------------------
    COV_FWD_CLAMP: cover property (over_pos ##1 torque_limited_out);
    COV_EXT_ON:    cover property (ext_on[0] && fwd_ext_reg < fwd_int_reg ##1 over_pos);
    COV_REV_CLAMP: cover property (ext_on[1] && over_neg);
    COV_DIR_SWAP:  cover property (cfg_reg[STL_CFG_DIR_SEL] && over_neg);
    COV_MOT_CAP:   cover property (over_pos && pos_lim == mot_max_reg);
endmodule : stl_top
`default_nettype wire

// [src/stl_pkg.sv]
// package: register map, field layout, reset values and limits for torque limit select
package stl_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] STL_OFS_FWD_INT = 8'h00;
    localparam logic [7:0] STL_OFS_REV_INT = 8'h04;
    localparam logic [7:0] STL_OFS_FWD_EXT = 8'h08;
    localparam logic [7:0] STL_OFS_REV_EXT = 8'h0C;
    localparam logic [7:0] STL_OFS_CONFIG  = 8'h10;
    localparam logic [7:0] STL_OFS_MOT_MAX = 8'h14;
    localparam logic [7:0] STL_OFS_STATUS  = 8'h18;
    localparam logic [7:0] STL_OFS_EFF_LIM = 8'h1C;

    // ------------------------------------------------------------
    // limit range and reset values, unit is 1 % of rated torque
    // ------------------------------------------------------------
    localparam int          STL_LIM_W       = 16;
    localparam logic [15:0] STL_LIM_MAX     = 16'h0320;
    localparam logic [15:0] STL_INT_RST     = 16'h0320;
    localparam logic [15:0] STL_EXT_RST     = 16'h0064;
    localparam logic [15:0] STL_MOT_MAX_RST = 16'h012C;

    // ------------------------------------------------------------
    // config register fields
    // ------------------------------------------------------------
    localparam int         STL_CFG_FWD_ALLOC = 0;
    localparam int         STL_CFG_REV_ALLOC = 1;
    localparam int         STL_CFG_OUT_ALLOC = 2;
    localparam int         STL_CFG_DIR_SEL   = 3;
    localparam int         STL_CFG_W         = 4;
    localparam logic [3:0] STL_CFG_RST       = 4'h0;

    // ------------------------------------------------------------
    // status register fields
    // ------------------------------------------------------------
    localparam int STL_ST_LIMITED = 0;
    localparam int STL_ST_FWD_IN  = 1;
    localparam int STL_ST_REV_IN  = 2;

    // ------------------------------------------------------------
    // ahb constants
    // ------------------------------------------------------------
    localparam logic [1:0] STL_HTRANS_NONSEQ = 2'h2;
    localparam logic       STL_HRESP_OKAY    = 1'b0;

endpackage : stl_pkg

// [src/stl_dir_limit.sv]
// one direction's effective torque limit
`timescale 1ns/100ps
`default_nettype none
module stl_dir_limit
    import stl_pkg::*;
(
    input  wire logic [stl_pkg::STL_LIM_W-1:0] int_lim,
    input  wire logic [stl_pkg::STL_LIM_W-1:0] ext_lim,
    input  wire logic                          ext_on,
    input  wire logic [stl_pkg::STL_LIM_W-1:0] motor_max,
    output var  logic [stl_pkg::STL_LIM_W-1:0] eff_lim
);
    logic [STL_LIM_W-1:0] sel_lim;

    always_comb begin
        sel_lim = int_lim;
        if (ext_on && (ext_lim < int_lim)) begin
            sel_lim = ext_lim;
        end
        eff_lim = (sel_lim > motor_max) ? motor_max : sel_lim;
    end
endmodule : stl_dir_limit
`default_nettype wire

// [dv/stl_host_model.sv]
// host controller model: drives the two external limit inputs
`timescale 1ns/100ps
`default_nettype none
module stl_host_model (
    input  wire logic sys_clk,
    input  wire logic reset_n,
    input  wire logic want_fwd,
    input  wire logic want_rev,
    output var  logic fwd_ext_limit_in,
    output var  logic rev_ext_limit_in
);
    // ------------------------------------------------------------
    // contact outputs, released in reset
    // ------------------------------------------------------------
    // registered so the contacts change just after an edge, like a real output card
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            fwd_ext_limit_in <= 1'b0;
            rev_ext_limit_in <= 1'b0;
        end else begin
            fwd_ext_limit_in <= want_fwd;
            rev_ext_limit_in <= want_rev;
        end
    end
endmodule : stl_host_model
`default_nettype wire

// [dv/tb_servo_torque_limit_select.sv]
// testbench: register access and clamp checks for torque limit select
`timescale 1ns/100ps
`default_nettype none
module tb_servo_torque_limit_select;
    import stl_pkg::*;
    logic               sys_clk;
    logic               reset_n;
    logic               hsel;
    logic [31:0]        haddr;
    logic [1:0]         htrans;
    logic               hwrite;
    logic [2:0]         hsize;
    logic [31:0]        hwdata;
    logic               hreadyout;
    logic               hresp;
    logic [31:0]        hrdata;
    logic               want_fwd;
    logic               want_rev;
    logic               fwd_in;
    logic               rev_in;
    logic signed [15:0] torque_req;
    logic signed [15:0] torque_out;
    logic               limited;
    logic [31:0]        rd;
    int                 fail_count;
    int                 num_checks;

    // ------------------------------------------------------------
    // clock, design and host
    // ------------------------------------------------------------
    initial sys_clk = 1'b0;
    always #5 sys_clk = ~sys_clk;

    stl_top DUT (
        .sys_clk            (sys_clk),
        .reset_n            (reset_n),
        .hsel               (hsel),
        .haddr              (haddr),
        .htrans             (htrans),
        .hwrite             (hwrite),
        .hsize              (hsize),
        .hwdata             (hwdata),
        .hready             (hreadyout),
        .hreadyout          (hreadyout),
        .hresp              (hresp),
        .hrdata             (hrdata),
        .fwd_ext_limit_in   (fwd_in),
        .rev_ext_limit_in   (rev_in),
        .torque_req         (torque_req),
        .torque_out         (torque_out),
        .torque_limited_out (limited)
    );

    stl_host_model host_i (
        .sys_clk          (sys_clk),
        .reset_n          (reset_n),
        .want_fwd         (want_fwd),
        .want_rev         (want_rev),
        .fwd_ext_limit_in (fwd_in),
        .rev_ext_limit_in (rev_in)
    );

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic conclude();
        if (fail_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude

    // one single word transfer; read data lands in rd
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge sys_clk);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= STL_HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus

    task automatic check_reg(input logic [7:0] a, input logic [31:0] exp);
        bus(a, 1'b0, 32'h00000000);
        num_checks++;
        if (rd !== exp || hresp !== STL_HRESP_OKAY) begin
            fail_count++;
            $display("[ERR] %0t read %h got %h want %h", $time, a, rd, exp);
        end
    endtask : check_reg

    // result is registered, so look half a cycle after the edge that samples the request
    task automatic check_trq(input logic signed [15:0] req,
                             input logic signed [15:0] exp, input logic lim);
        @(posedge sys_clk);
        torque_req <= req;
        @(posedge sys_clk);
        @(negedge sys_clk);
        num_checks++;
        if (torque_out !== exp || limited !== lim) begin
            fail_count++;
            $display("[ERR] %0t torque %0d got %0d/%b want %0d/%b",
                     $time, req, torque_out, limited, exp, lim);
        end
    endtask : check_trq

    task automatic host(input logic f, input logic r);
        @(posedge sys_clk);
        want_fwd <= f;
        want_rev <= r;
        repeat (2) @(posedge sys_clk);
    endtask : host

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    // whole sequence needs well under 1000 cycles
    initial begin
        #50000;
        fail_count++;
        conclude();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        reset_n = 1'b0; hsel = 1'b0; haddr = 32'h00000000; htrans = 2'h0;
        hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h00000000; want_fwd = 1'b0;
        want_rev = 1'b0; torque_req = 16'sh0000; fail_count = 0; num_checks = 0;
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        check_reg(STL_OFS_FWD_INT, 32'h00000320);
        check_reg(STL_OFS_REV_INT, 32'h00000320);
        check_reg(STL_OFS_FWD_EXT, 32'h00000064);
        check_reg(STL_OFS_REV_EXT, 32'h00000064);
        check_reg(STL_OFS_MOT_MAX, 32'h0000012C);
        check_reg(STL_OFS_CONFIG, 32'h00000000);
        check_reg(8'h20, 32'h00000000);
        bus(STL_OFS_FWD_EXT, 1'b1, 32'h00000321);
        check_reg(STL_OFS_FWD_EXT, 32'h00000320);
        bus(STL_OFS_FWD_EXT, 1'b1, 32'h00000000);
        check_reg(STL_OFS_FWD_EXT, 32'h00000000);
        bus(STL_OFS_CONFIG, 1'b1, 32'h00000004);
        check_trq(16'sh0384, 16'sh012C, 1'b1);
        check_trq(-16'sh0384, -16'sh012C, 1'b1);
        check_trq(16'sh012C, 16'sh012C, 1'b0);
        check_trq(16'sh00C8, 16'sh00C8, 1'b0);
        bus(STL_OFS_CONFIG, 1'b1, 32'h00000000);
        check_trq(16'sh0384, 16'sh012C, 1'b0);
        bus(STL_OFS_MOT_MAX, 1'b1, 32'h00000320);
        bus(STL_OFS_FWD_INT, 1'b1, 32'h000001F4);
        bus(STL_OFS_FWD_EXT, 1'b1, 32'h00000064);
        bus(STL_OFS_CONFIG, 1'b1, 32'h00000004);
        check_trq(16'sh0258, 16'sh01F4, 1'b1);
        check_trq(-16'sh0258, -16'sh0258, 1'b0);
        host(1'b1, 1'b1);
        check_trq(16'sh0258, 16'sh01F4, 1'b1);
        check_trq(-16'sh0258, -16'sh0258, 1'b0);
        bus(STL_OFS_CONFIG, 1'b1, 32'h00000005);
        check_trq(16'sh0258, 16'sh0064, 1'b1);
        check_reg(STL_OFS_STATUS, 32'h00000007);
        check_trq(-16'sh0258, -16'sh0258, 1'b0);
        bus(STL_OFS_CONFIG, 1'b1, 32'h00000007);
        check_trq(-16'sh0258, -16'sh0064, 1'b1);
        bus(STL_OFS_FWD_EXT, 1'b1, 32'h000002BC);
        check_trq(16'sh0258, 16'sh01F4, 1'b1);
        check_reg(STL_OFS_EFF_LIM, 32'h006401F4);
        host(1'b0, 1'b0);
        check_trq(-16'sh0258, -16'sh0258, 1'b0);
        check_trq(16'sh0258, 16'sh01F4, 1'b1);
        bus(STL_OFS_CONFIG, 1'b1, 32'h0000000C);
        check_reg(STL_OFS_CONFIG, 32'h0000000C);
        check_trq(16'sh0258, 16'sh0258, 1'b0);
        check_trq(-16'sh0258, -16'sh01F4, 1'b1);
        bus(STL_OFS_MOT_MAX, 1'b1, 32'h00000190);
        check_trq(16'sh0258, 16'sh0190, 1'b1);
        conclude();
    end
endmodule : tb_servo_torque_limit_select
`default_nettype wire
